// [logic/elr_cmd.sv]
// Extended read command block: task-file registers over APB, 48-bit
// address and 16-bit count decode, stream read with continuous mode.
// Assumes a sector mover that pulses sec_done per sector moved by DMA.
// Behaviour
// - Count bytes combine low current, high previous
// - Zero count means 65,536 sectors
// - Address bytes in place; first failing address back
// - Upper select picks high address bytes on read
// - Opcode 2Ah, device/head top bits ones
// - Stream read moves 1 to 65536 sectors
// - Continuous clear gives normal streaming mode
// - Continuous mode: full length, never error bit
// - Stream-error flag, status bit 5, on bad data
// - Continuous errors never abort; end with flag
// - Log crc, unc, not found, aborted kinds
// - Limit expiry stops command, sets timeout bit
// - Always attempt full length within the limit
// - Stream identifier selects configured settings
// - Limit is previous feature times time unit
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module elr_cmd
   import elr_pkg::*;
#(
   parameter int COMPLETION_TIME_LIMIT_UNIT_US = 1       // Time unit of the completion limit
) (
   input  wire logic        clk_sys,    // System clock, 100 MHz
   input  wire logic        rst_b,      // Async reset, active low
   input  wire logic        psel,       // APB select
   input  wire logic        penable,    // APB enable
   input  wire logic        pwrite,     // APB write
   input  wire logic [7:0]  paddr,      // APB byte address
   input  wire logic [31:0] pwdata,     // APB write data
   output logic [31:0]      prdata,     // APB read data
   output logic             pready,     // APB ready
   output logic             pslverr,    // APB unmapped address
   input  wire logic        sec_done,   // Sector moved to host
   input  wire logic [3:0]  sec_err,    // Errors: crc, unc, address_not_found_flag, aborted_command_flag
   output logic             xfer_req,   // Sector mover run request
   output logic             xfer_cont,  // Continuous mode active
   output logic [47:0]      xfer_lba,   // Address of next sector
   output logic             irq         // Level interrupt
);
   typedef struct packed {
      elr_state_t                 state;
      logic [7:0]                 feat_cur;
      logic [7:0]                 feat_prev;
      logic [15:0]                cnt;
      logic [47:0]                lba;
      logic [7:0]                 devhead;
      logic                       upper_byte_select;
      logic                       stream_error_flag;
      logic                       err;
      logic [7:0]                 errlog;
      logic [1:0]                 irq_st;
      logic [1:0]                 irq_msk;
      logic [STREAM_IDS-1:0][7:0] sdef;
      logic [16:0]                rem;
      logic [47:0]                cur_lba;
      logic                       cont;
      logic                       use_lim;
      logic [31:0]                prdata;
      logic                       pready;
      logic                       pslverr;
      logic                       irq;
   } elr_st_t;

   elr_st_t s_q, s_d;

   logic           us_tick;
   logic           tmo;
   logic           start;
   logic [7:0]     lim_sel;
   logic [LIM_W-1:0] lim_us;
   logic [2:0]     sid;
   logic           wr_acc;
   logic           rd_set;
   logic [7:0]     status;
   logic           mapped;

   // Microsecond enable from the system clock
   elr_down_cnt #(.W(US_CNT_W)) u_us_div (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .load     (s_q.state == ST_IDLE),
      .load_val (US_CNT_W'(US_CYCLES)),
      .auto_rl  (1'b1),
      .en       (1'b1),
      .expire   (us_tick)
   );

   // Completion limit countdown in microseconds
   elr_down_cnt #(.W(LIM_W)) u_limit (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .load     (start),
      .load_val (lim_us),
      .auto_rl  (1'b0),
      .en       (us_tick),
      .expire   (tmo)
   );

   // Stream settings and the limit chosen for this command
   always_comb begin
      sid     = s_q.feat_cur[2:0];
      lim_sel = (s_q.feat_prev != RST_BYTE) ? s_q.feat_prev : s_q.sdef[sid];
      lim_us  = LIM_W'(lim_sel * COMPLETION_TIME_LIMIT_UNIT_US);
   end

   // Bus phases: zero-wait slave, ready rises in the access cycle
   assign wr_acc = psel && penable && pready && pwrite;
   assign rd_set = psel && !penable;
   assign start  = wr_acc && paddr == OFS_CMD_STAT && s_q.state == ST_IDLE
                   && (pwdata[7:0] == CMD_READ_EXT
                       || (pwdata[7:0] == CMD_READ_STREAM
                           && s_q.devhead[7:DEVHEAD_ONES] == DEVHEAD_ONES_VAL));

   // Status seen by the host; busy holds until the ending cycle is over
   always_comb begin
      status            = RST_BYTE;
      status[STAT_BUSY] = (s_q.state != ST_IDLE);
      status[STAT_RDY]  = 1'b1;
      status[STAT_SE]   = s_q.stream_error_flag;
      status[STAT_DWE]  = 1'b0;
      status[STAT_DRQ]  = (s_q.state == ST_XFER);
      status[STAT_ERR]  = s_q.err;
   end

   // Address decode; reserved offsets answer with an error
   always_comb begin
      mapped = 1'b1;
      if (paddr == OFS_FEAT_CUR || paddr == OFS_FEAT_PREV) begin
         mapped = 1'b1;
      end else if (paddr == OFS_CNT_CUR || paddr == OFS_CNT_PREV) begin
         mapped = 1'b1;
      end else if (paddr >= OFS_SECNUM && paddr <= OFS_STRM_CFG
                   && paddr[1:0] == 2'h0) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   // Next state of the whole block
   always_comb begin
      s_d         = s_q;
      s_d.pready  = rd_set;
      s_d.pslverr = rd_set && !mapped;
      s_d.prdata  = RD_ZERO;
      s_d.irq     = |(s_q.irq_st & s_q.irq_msk);

      // Readback, selected in the setup cycle
      if (rd_set && !pwrite) begin
         if (paddr == OFS_FEAT_CUR) begin
            s_d.prdata[7:0] = s_q.feat_cur;
         end else if (paddr == OFS_FEAT_PREV) begin
            s_d.prdata[7:0] = s_q.feat_prev;
         end else if (paddr == OFS_CNT_CUR) begin
            s_d.prdata[7:0] = s_q.upper_byte_select ? s_q.cnt[15:8] : s_q.cnt[7:0];
         end else if (paddr == OFS_SECNUM) begin
            s_d.prdata[7:0] = s_q.upper_byte_select ? s_q.lba[31:24] : s_q.lba[7:0];
         end else if (paddr == OFS_CYLLO) begin
            s_d.prdata[7:0] = s_q.upper_byte_select ? s_q.lba[39:32] : s_q.lba[15:8];
         end else if (paddr == OFS_CYLHI) begin
            s_d.prdata[7:0] = s_q.upper_byte_select ? s_q.lba[47:40] : s_q.lba[23:16];
         end else if (paddr == OFS_DEVHEAD) begin
            s_d.prdata[7:0] = s_q.devhead;
         end else if (paddr == OFS_CMD_STAT) begin
            s_d.prdata[7:0] = status;
         end else if (paddr == OFS_ERROR) begin
            s_d.prdata[7:0] = s_q.errlog & ERR_USED_MASK;
         end else if (paddr == OFS_CTRL) begin
            s_d.prdata[CTRL_UPPER_SEL] = s_q.upper_byte_select;
         end else if (paddr == OFS_IRQ_STAT) begin
            s_d.prdata[1:0] = s_q.irq_st;
         end else if (paddr == OFS_IRQ_MASK) begin
            s_d.prdata[1:0] = s_q.irq_msk;
         end else begin
            s_d.prdata = RD_ZERO;
         end
      end

      // Task-file writes; taken only while idle so a command keeps its inputs
      if (wr_acc && s_q.state == ST_IDLE) begin
         if (paddr == OFS_FEAT_CUR) begin
            s_d.feat_cur = pwdata[7:0];
         end else if (paddr == OFS_FEAT_PREV) begin
            s_d.feat_prev = pwdata[7:0];
         end else if (paddr == OFS_CNT_CUR) begin
            s_d.cnt[7:0] = pwdata[7:0];
         end else if (paddr == OFS_CNT_PREV) begin
            s_d.cnt[15:8] = pwdata[7:0];
         end else if (paddr == OFS_SECNUM) begin
            s_d.lba[7:0] = pwdata[7:0];
         end else if (paddr == OFS_CYLLO) begin
            s_d.lba[15:8] = pwdata[7:0];
         end else if (paddr == OFS_CYLHI) begin
            s_d.lba[23:16] = pwdata[7:0];
         end else if (paddr == OFS_SECNUM_P) begin
            s_d.lba[31:24] = pwdata[7:0];
         end else if (paddr == OFS_CYLLO_P) begin
            s_d.lba[39:32] = pwdata[7:0];
         end else if (paddr == OFS_CYLHI_P) begin
            s_d.lba[47:40] = pwdata[7:0];
         end else if (paddr == OFS_DEVHEAD) begin
            s_d.devhead = pwdata[7:0];
         end else if (paddr == OFS_STRM_CFG) begin
            s_d.sdef[pwdata[CFG_SID_LSB +: 3]] = pwdata[7:0];
         end
      end

      // Control and interrupt registers are writable at any time
      if (wr_acc) begin
         if (paddr == OFS_CTRL) begin
            s_d.upper_byte_select = pwdata[CTRL_UPPER_SEL];
         end else if (paddr == OFS_IRQ_STAT) begin
            s_d.irq_st = s_q.irq_st & ~pwdata[1:0];
         end else if (paddr == OFS_IRQ_MASK) begin
            s_d.irq_msk = pwdata[1:0];
         end
      end

      // Command sequencer
      case (s_q.state)
         ST_IDLE: begin
            if (start) begin
               s_d.rem = (s_q.cnt == 16'h0000) ? MAX_SECTORS
                                               : {1'b0, s_q.cnt};
               s_d.cur_lba = s_q.lba;
               s_d.cont    = (pwdata[7:0] == CMD_READ_STREAM)
                             && s_q.feat_cur[FEAT_CONT_RD];
               s_d.use_lim = (pwdata[7:0] == CMD_READ_STREAM) && lim_sel != RST_BYTE;
               s_d.errlog  = RST_BYTE;
               s_d.err     = 1'b0;
               s_d.stream_error_flag = 1'b0;
               s_d.state   = ST_XFER;
            end else if (wr_acc && paddr == OFS_CMD_STAT) begin
               // Unknown opcode or bad device/head: abort at once
               s_d.errlog           = RST_BYTE;
               s_d.errlog[ERR_ABORTED_COMMAND_FLAG] = 1'b1;
               s_d.err              = 1'b1;
               s_d.state            = ST_ENDS;
            end
         end
         ST_XFER: begin
            if (sec_done) begin
               s_d.cur_lba = s_q.cur_lba + 48'h1;
               s_d.rem     = s_q.rem - 17'h1;
               if (s_q.rem == 17'h1) begin
                  s_d.state = ST_ENDS;
               end
               if (sec_err != 4'h0) begin
                  s_d.errlog[ERR_INTERFACE_CRC_FLAG] = s_q.errlog[ERR_INTERFACE_CRC_FLAG] | sec_err[3];
                  s_d.errlog[ERR_UNC]  = s_q.errlog[ERR_UNC]  | sec_err[2];
                  s_d.errlog[ERR_ADDRESS_NOT_FOUND_FLAG] = s_q.errlog[ERR_ADDRESS_NOT_FOUND_FLAG] | sec_err[1];
                  s_d.errlog[ERR_ABORTED_COMMAND_FLAG] = s_q.errlog[ERR_ABORTED_COMMAND_FLAG] | sec_err[0];
                  if (s_q.cont) begin
                     s_d.stream_error_flag = 1'b1;
                  end else begin
                     // Stop at the failing sector and report where
                     s_d.lba   = s_q.cur_lba;
                     s_d.cnt   = s_q.rem[15:0];
                     s_d.err   = 1'b1;
                     s_d.state = ST_ENDS;
                  end
               end
            end
            // Expiry beats a sector finishing in the same cycle
            if (tmo && s_q.use_lim) begin
               s_d.errlog[ERR_COMPLETION_TIMEOUT_FLAG] = 1'b1;
               s_d.err   = !s_q.cont;
               s_d.stream_error_flag = s_q.cont || s_d.stream_error_flag;
               s_d.state = ST_ENDS;
            end
         end
         ST_ENDS: begin
            s_d.state = ST_IDLE;
            s_d.cont  = 1'b0;
         end
         default: begin
            s_d.state = ST_IDLE;
         end
      endcase

      // Sticky events; a set in the clearing cycle wins
      if (s_q.state == ST_ENDS) begin
         s_d.irq_st[IRQ_DONE] = 1'b1;
         s_d.irq_st[IRQ_SERR] = s_d.irq_st[IRQ_SERR] | s_q.stream_error_flag;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops; xfer_req is decoded from the state
   assign prdata    = s_q.prdata;
   assign pready    = s_q.pready;
   assign pslverr   = s_q.pslverr;
   assign irq       = s_q.irq;
   assign xfer_req  = (s_q.state == ST_XFER);
   assign xfer_cont = s_q.cont;
   assign xfer_lba  = s_q.cur_lba;

   // Checks
   a_zero_count_max: assert property (@(posedge clk_sys) disable iff (!rst_b)
      start && s_q.cnt == 16'h0000 |=> s_q.rem == 17'h10000)
      else $error("zero count did not load 65536");
   a_count_combine: assert property (@(posedge clk_sys) disable iff (!rst_b)
      start && s_q.cnt != 16'h0000 |=> s_q.rem == {1'b0, $past(s_q.cnt)})
      else $error("count bytes not combined");
   a_cont_no_err: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_q.state == ST_XFER && s_q.cont |=> !s_q.err)
      else $error("error bit set in continuous mode");
   a_cont_err_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_q.state == ST_XFER && s_q.cont && sec_done && sec_err != 4'h0
      |=> s_q.stream_error_flag && s_q.errlog != 8'h00)
      else $error("stream error flag missing");
   a_cont_not_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_q.state == ST_XFER && s_q.cont && sec_done && s_q.rem > 17'h1 && !tmo
      |=> s_q.state == ST_XFER)
      else $error("continuous read aborted on error");
   a_first_fail_lba: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_q.state == ST_XFER && !s_q.cont && sec_done && sec_err != 4'h0
      |=> s_q.lba == $past(s_q.cur_lba) ##1 s_q.state == ST_IDLE)
      else $error("failing address not reported");
   a_timeout_ends: assert property (@(posedge clk_sys) disable iff (!rst_b)
      s_q.state == ST_XFER && tmo && s_q.use_lim
      |=> s_q.errlog[ERR_COMPLETION_TIMEOUT_FLAG] ##1 !status[STAT_BUSY])
      else $error("timeout did not end command");
   a_upper_readback: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rd_set && !pwrite && paddr == OFS_SECNUM
      |=> s_q.prdata[7:0] == ($past(s_q.upper_byte_select) ? $past(s_q.lba[31:24])
                                                          : $past(s_q.lba[7:0])))
      else $error("address byte readback wrong");
   a_error_zero_bits: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (s_q.errlog & ~ERR_USED_MASK) == 8'h00)
      else $error("reserved error bits set");
   a_stream_devhead: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_acc && paddr == OFS_CMD_STAT && s_q.state == ST_IDLE
      && pwdata[7:0] == CMD_READ_STREAM && s_q.devhead[7:5] != 3'h7
      |=> s_q.errlog[ERR_ABORTED_COMMAND_FLAG] && s_q.state == ST_ENDS)
      else $error("bad device/head not aborted");
endmodule

// [logic/elr_pkg.sv]
// Constants for the extended read command block: register map, fields,
// opcodes and timing. Shared by the command block and its counter.
package elr_pkg;
   // APB byte offsets, one aligned word per register
   localparam logic [7:0] OFS_FEAT_CUR  = 8'h00;
   localparam logic [7:0] OFS_FEAT_PREV = 8'h04;
   localparam logic [7:0] OFS_CNT_CUR   = 8'h08;
   localparam logic [7:0] OFS_CNT_PREV  = 8'h0C;
   localparam logic [7:0] OFS_SECNUM    = 8'h10;
   localparam logic [7:0] OFS_CYLLO     = 8'h14;
   localparam logic [7:0] OFS_CYLHI     = 8'h18;
   localparam logic [7:0] OFS_SECNUM_P  = 8'h1C;
   localparam logic [7:0] OFS_CYLLO_P   = 8'h20;
   localparam logic [7:0] OFS_CYLHI_P   = 8'h24;
   localparam logic [7:0] OFS_DEVHEAD   = 8'h28;
   localparam logic [7:0] OFS_CMD_STAT  = 8'h2C;
   localparam logic [7:0] OFS_ERROR     = 8'h30;
   localparam logic [7:0] OFS_CTRL      = 8'h34;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h38;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h3C;
   localparam logic [7:0] OFS_STRM_CFG  = 8'h40;

   // Opcodes
   localparam logic [7:0] CMD_READ_EXT    = 8'h24;
   localparam logic [7:0] CMD_READ_STREAM = 8'h2A;

   // Field positions
   localparam int CTRL_UPPER_SEL = 0;
   localparam int FEAT_CONT_RD   = 6;
   localparam int DEVHEAD_ONES   = 5;
   localparam logic [2:0] DEVHEAD_ONES_VAL = 3'h7;
   localparam int STAT_BUSY = 7;
   localparam int STAT_RDY  = 6;
   localparam int STAT_SE   = 5;
   localparam int STAT_DWE  = 4;
   localparam int STAT_DRQ  = 3;
   localparam int STAT_ERR  = 0;
   localparam int ERR_INTERFACE_CRC_FLAG  = 7;
   localparam int ERR_UNC   = 6;
   localparam int ERR_ADDRESS_NOT_FOUND_FLAG  = 4;
   localparam int ERR_ABORTED_COMMAND_FLAG  = 2;
   localparam int ERR_COMPLETION_TIMEOUT_FLAG  = 0;
   localparam logic [7:0] ERR_USED_MASK = 8'hD5;
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_SERR  = 1;
   localparam int CFG_SID_LSB = 8;

   // Counts and reset values
   localparam logic [16:0] MAX_SECTORS = 17'h10000;
   localparam int          STREAM_IDS  = 8;
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

   // Timing: completion limit is counted in microseconds
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS         = 1000;
   localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
   localparam int US_CNT_W      = 8;
   localparam int LIM_W         = 24;

   // Command sequencer, Gray coded along idle, transfer, ending
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01,
      ST_ENDS = 2'b11
   } elr_state_t;
endpackage

// [logic/elr_down_cnt.sv]
// Loadable down counter with a registered expiry pulse.
// Assumes one clock; enable is a one-cycle qualifier from the caller.
`timescale 1ns/100ps
module elr_down_cnt
   import elr_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk_sys,   // System clock
   input  wire logic         rst_b,     // Async reset, active low
   input  wire logic         load,      // Load start value
   input  wire logic [W-1:0] load_val,  // Start value
   input  wire logic         auto_rl,   // Reload on expiry
   input  wire logic         en,        // Count enable
   output logic              expire     // One-cycle expiry pulse
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         exp;
   } elr_cnt_st_t;

   elr_cnt_st_t s_q, s_d;

   // Count down; stop at zero unless reloading as a divider
   always_comb begin
      s_d     = s_q;
      s_d.exp = 1'b0;
      if (load) begin
         s_d.cnt = load_val;
      end else if (en && s_q.cnt != '0) begin
         s_d.exp = (s_q.cnt == W'(1));
         s_d.cnt = (s_d.exp && auto_rl) ? load_val : s_q.cnt - W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign expire = s_q.exp;
endmodule

// [test/elr_mover_model.sv]
// Sector mover model standing behind the transfer request port.
// Assumes one clock; the bench commands stalls and error patterns.
`timescale 1ns/100ps
module elr_mover_model (
   input  wire logic       clk_sys,   // System clock
   input  wire logic       rst_b,     // Async reset, active low
   input  wire logic       xfer_req,  // Run request from the block
   input  wire logic       stall,     // Hold off sectors
   input  wire logic [3:0] err_pat,   // Errors reported per sector
   output logic            sec_done,  // Sector moved
   output logic [3:0]      sec_err    // Errors with the sector
);
   logic [3:0] junk_q;  // Changing pattern between sectors

   // One sector per cycle while asked; errors toggle between 5h and Ah between pulses
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sec_done <= 1'b0;
         sec_err  <= 4'h0;
         junk_q   <= 4'h5;
      end else begin
         sec_done <= xfer_req && !stall;
         junk_q   <= ~junk_q;
         sec_err  <= (xfer_req && !stall) ? err_pat : junk_q;
      end
   end
endmodule

// [test/elr_cmd_tb_top.sv]
// Self-checking bench for the extended read command block.
// Assumes the block answers APB in one access cycle or more.
`timescale 1ns/100ps
module elr_cmd_tb_top;
   import elr_pkg::*;
   logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
   logic        sec_done, xfer_req, xfer_cont, irq, stall, slv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [3:0]  sec_err, err_pat;
   logic [47:0] xfer_lba, lba;
   logic [15:0] n_sec;
   int          errors, n_tests, moved, i, j;

   elr_cmd #(.COMPLETION_TIME_LIMIT_UNIT_US(1)) elr_cmd_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sec_done(sec_done), .sec_err(sec_err),
      .xfer_req(xfer_req), .xfer_cont(xfer_cont), .xfer_lba(xfer_lba), .irq(irq));
   elr_mover_model elr_mover_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .xfer_req(xfer_req), .stall(stall), .err_pat(err_pat), .sec_done(sec_done),
      .sec_err(sec_err));

   // Clock and sector tally
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (xfer_req === 1'b1 && sec_done === 1'b1) moved++;
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Error log layout for a sector error pattern
   function logic [31:0] err_bits(input logic [3:0] p);
      return {24'h0, p[3], p[2], 1'b0, p[1], 1'b0, p[0], 2'b00};
   endfunction

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // One APB transfer; request held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd      = prdata;
      slv     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Load parameters, issue, check start, then poll until not busy
   task run_cmd(input logic [7:0] op, dh, fc, fp, input logic [15:0] n, input logic hold);
      apb(1'b1, OFS_FEAT_CUR, {24'h0, fc});
      apb(1'b1, OFS_FEAT_PREV, {24'h0, fp});
      apb(1'b1, OFS_CNT_CUR, {24'h0, n[7:0]});
      apb(1'b1, OFS_CNT_PREV, {24'h0, n[15:8]});
      for (j = 0; j < 3; j++) begin
         apb(1'b1, OFS_SECNUM + 8'(4 * j), {24'h0, lba[8*j+:8]});
         apb(1'b1, OFS_SECNUM_P + 8'(4 * j), {24'h0, lba[24+8*j+:8]});
      end
      apb(1'b1, OFS_DEVHEAD, {24'h0, dh});
      stall <= 1'b1;
      moved = 0;
      apb(1'b1, OFS_CMD_STAT, {24'h0, op});
      @(negedge clk_sys);
      if (dh[7:5] == 3'h7) chk({31'h0, xfer_cont}, {31'h0, fc[6] && op == CMD_READ_STREAM});
      if (dh[7:5] == 3'h7) chk(xfer_lba[31:0], lba[31:0]);
      @(posedge clk_sys);
      stall <= hold;
      for (i = 0; i < 30000; i++) begin
         apb(1'b0, OFS_CMD_STAT, 32'h0);
         if (rd[STAT_BUSY] === 1'b0) break;
      end
      // A poll that runs out leaves busy set and counts as a mismatch
      chk({31'h0, rd[STAT_BUSY]}, 32'h0);
      stall <= 1'b0;
   endtask

   // Watchdog sized for the longest run plus margin, kept under 100k cycles
   initial begin
      #900000;
      errors++;
      summarize();
   end

   initial begin
      clk_sys = 1'b0;
      rst_b   = 1'b0;
      {psel, penable, pwrite, stall} = 4'h0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      err_pat = 4'h0;
      seed    = 32'h0001_4D4F;
      lba     = 48'h0;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      apb(1'b0, OFS_CMD_STAT, 32'h0);
      chk(rd, 32'h40);
      apb(1'b0, 8'h44, 32'h0);
      chk({31'h0, slv}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      // Plain extended read, random address and short count
      lba = 48'({rnd(), rnd()});
      n_sec = 16'(rnd() % 40 + 1);
      run_cmd(CMD_READ_EXT, 8'hE0, 8'h00, 8'h00, n_sec, 1'b0);
      chk(moved, {16'h0, n_sec});
      apb(1'b0, OFS_ERROR, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h3);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // Count pairing checked through sectors moved
      run_cmd(CMD_READ_EXT, 8'hE0, 8'h00, 8'h00, 16'h0102, 1'b0);
      chk(moved, 32'h102);
      // Failing first sector reports its address and remaining count
      err_pat = 4'h4;
      lba = 48'({rnd(), rnd()});
      run_cmd(CMD_READ_EXT, 8'hE0, 8'h00, 8'h00, 16'h0005, 1'b0);
      chk(rd, 32'h41);
      apb(1'b0, OFS_ERROR, 32'h0);
      chk(rd, err_bits(4'h4));
      apb(1'b0, OFS_CNT_CUR, 32'h0);
      chk(rd, 32'h5);
      for (i = 0; i < 6; i++) begin
         apb(1'b1, OFS_CTRL, 32'(i / 3));
         apb(1'b0, OFS_SECNUM + 8'(4 * (i % 3)), 32'h0);
         chk(rd, {24'h0, lba[8*i+:8]});
      end
      apb(1'b1, OFS_CTRL, 32'h0);
      // Stream read with wrong device/head bits is refused
      err_pat = 4'h0;
      run_cmd(CMD_READ_STREAM, 8'h40, 8'h00, 8'h00, 16'h0004, 1'b0);
      chk(rd, 32'h41);
      apb(1'b0, OFS_ERROR, 32'h0);
      chk(rd, err_bits(4'h1));
      // Continuous reads run to length whatever the error kind
      for (int e = 0; e < 4; e++) begin
         err_pat = 4'h1 << e;
         lba = 48'({rnd(), rnd()});
         run_cmd(CMD_READ_STREAM, 8'hE0, 8'h40 | 8'(rnd() % 8), 8'h00, 16'(e + 3), 1'b0);
         chk(rd, 32'h60);
         chk(moved, e + 3);
         apb(1'b0, OFS_ERROR, 32'h0);
         chk(rd, err_bits(err_pat));
      end
      // Zero count in normal streaming mode moves the full maximum
      err_pat = 4'h0;
      run_cmd(CMD_READ_STREAM, 8'hE0, 8'h01, 8'h00, 16'h0000, 1'b0);
      chk(moved, 32'(MAX_SECTORS));
      chk(rd, 32'h40);
      // Completion limit of 2 us expires while the mover stalls
      run_cmd(CMD_READ_STREAM, 8'hE0, 8'h40, 8'h02, 16'h0064, 1'b1);
      chk(rd, 32'h60);
      apb(1'b0, OFS_ERROR, 32'h0);
      chk(rd, 32'h1);
      // Zero previous feature falls back to the stream's configured limit
      apb(1'b1, OFS_STRM_CFG, 32'h0000_0502);
      run_cmd(CMD_READ_STREAM, 8'hE0, 8'h05, 8'h00, 16'h0064, 1'b1);
      chk(rd, 32'h41);
      apb(1'b0, OFS_ERROR, 32'h0);
      chk(rd, 32'h1);
      summarize();
   end
endmodule
